// file: ecc_map.svh
// Widths and counts for the memory SEC-DED checker
`ifndef ECC_MAP_SVH
`define ECC_MAP_SVH

`define FL_DATA_W 64
`define FL_CHK_W 8
`define FL_WORD_W 72
`define FL_ADDR_W 16
`define DF_DATA_W 32
`define DF_CHK_W 7
`define DF_WORD_W 39
`define SR_DATA_W 32
`define SR_ADDR_W 16
`define SR_CHK_W 7
`define SR_WORD_W 39
`define SR_CHANNELS 2
`define RSP_DATA_W 64
`define ERR_LEAD_CYCLES 16

`endif

// file: ecc_pkg.sv
// Carrier types for the memory SEC-DED checker
`include "ecc_map.svh"
package ecc_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic erase;
    logic data_flash;
    logic [`FL_ADDR_W-1:0] addr;
    logic [`FL_DATA_W-1:0] wdata;
  } flash_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic data_flash;
    logic [`FL_ADDR_W-1:0] addr;
    logic [`FL_WORD_W-1:0] word;
  } flash_cmd_t;

  typedef struct packed {
    logic valid;
    logic [`FL_WORD_W-1:0] word;
  } flash_ret_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`SR_ADDR_W-1:0] addr;
    logic [`SR_DATA_W-1:0] wdata;
  } sram_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`SR_ADDR_W-1:0] addr;
    logic [`SR_WORD_W-1:0] word;
  } sram_cmd_t;

  typedef struct packed {
    logic valid;
    logic [`SR_WORD_W-1:0] word;
  } sram_ret_t;

  typedef struct packed {
    logic valid;
    logic single_bit_error;
    logic ue;
    logic [`RSP_DATA_W-1:0] rdata;
  } rsp_t;

  typedef enum logic [1:0] {SRC_FLASH, SRC_SRAM0, SRC_SRAM1} err_src_t;

endpackage

// file: error_reporter.sv
// Corrected-error status and uncorrectable-fault reset sequencing
`timescale 1ns/1ps
module error_reporter #(
  parameter int ADDR_W = 16,
  parameter int LEAD = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic sbe_event,
  input wire logic [ADDR_W-1:0] sbe_addr,
  input ecc_pkg::err_src_t sbe_src,
  input wire logic ue_event,
  input wire logic prog_reset,
  input wire logic irq_enable,
  output logic [ADDR_W-1:0] last_corr_addr,
  output ecc_pkg::err_src_t last_corr_src,
  output logic sbe_irq,
  output logic error_out,
  output logic reset_req
);
  if (LEAD < 2 || LEAD > 255) begin : g_bad
    $error("error_reporter: LEAD out of range");
  end

  typedef enum logic [1:0] {FC_IDLE, FC_ALARM, FC_RESET} fc_state_t;

  fc_state_t state_reg;
  logic [7:0] lead_cnt_reg;
  logic prog_seen_reg;

  // ----------------------------------------
  // Error status
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      last_corr_addr <= '0;
      last_corr_src <= ecc_pkg::SRC_FLASH;
      sbe_irq <= 1'b0;
    end else begin
      sbe_irq <= sbe_event && irq_enable;
      if (sbe_event) begin
        last_corr_addr <= sbe_addr;
        last_corr_src <= sbe_src;
      end
    end
  end

  // ----------------------------------------
  // Fault collection and reset
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= FC_IDLE;
      lead_cnt_reg <= 8'h00;
      error_out <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      unique case (state_reg)
        FC_IDLE: begin
          if (prog_reset) begin
            state_reg <= FC_RESET;
            reset_req <= 1'b1;
          end else if (ue_event) begin
            state_reg <= FC_ALARM;
            error_out <= 1'b1;
            lead_cnt_reg <= 8'(LEAD - 1);
          end
        end
        FC_ALARM: begin
          // Error pin leads the reset so the outside can see the cause
          if (prog_reset || lead_cnt_reg == 8'h00) begin
            state_reg <= FC_RESET;
            reset_req <= 1'b1;
          end else begin
            lead_cnt_reg <= lead_cnt_reg - 8'h01;
          end
        end
        FC_RESET: begin
          reset_req <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prog_seen_reg <= 1'b0;
    end else if (prog_reset) begin
      prog_seen_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  localparam int LEAD_M1 = LEAD - 1;

  sequence s_lead;
    ##LEAD_M1 (!reset_req || prog_seen_reg) ##1 reset_req;
  endsequence

  a_alarm_lead: assert property (
    $rose(error_out) && !prog_seen_reg |-> s_lead
  ) else $error("reset did not follow error output on time");

  a_sbe_record: assert property (
    sbe_event && irq_enable |=> sbe_irq && last_corr_addr == $past(sbe_addr)
  ) else $error("corrected error not recorded or signalled");

endmodule

// file: mem_array_model.sv
// Behavioural flash and SRAM arrays with fault injection
`timescale 1ns/1ps
module mem_array_model (
  input wire logic ref_clk,
  input ecc_pkg::flash_cmd_t flash_cmd,
  output ecc_pkg::flash_ret_t flash_ret,
  input ecc_pkg::sram_cmd_t [1:0] sram_cmd,
  output ecc_pkg::sram_ret_t [1:0] sram_ret,
  input wire logic [71:0] flip,
  input wire logic [15:0] addr_skew,
  input wire logic force_on,
  input wire logic [71:0] force_word,
  input wire logic [3:0] lag
);
  logic [71:0] mem [int];
  int key [3];
  int cnt [3];
  bit pend [3];
  logic ok;
  logic [71:0] w;

  initial begin
    flash_ret = '0;
    sram_ret = '0;
  end

  // Unwritten cells read as erased
  function automatic logic [71:0] fetch(input int k);
    return mem.exists(k) ? mem[k] : '1;
  endfunction

  task automatic step(input int c, input logic rd, input int k, output logic v,
                      output logic [71:0] d);
    v = 1'b0;
    d = '0;
    if (rd) begin
      pend[c] = 1'b1;
      cnt[c] = lag;
      key[c] = k;
    end else if (cnt[c] != 0) begin
      cnt[c]--;
    end
    if (pend[c] && cnt[c] == 0) begin
      v = 1'b1;
      pend[c] = 1'b0;
      d = force_on ? force_word : fetch(key[c]) ^ flip;
    end
  endtask

  // Released return lines toggle so a stale word never looks valid
  always @(posedge ref_clk) begin
    flash_ret.valid <= 1'b0;
    flash_ret.word <= ~flash_ret.word;
    if (flash_cmd.wr) mem[int'({flash_cmd.data_flash, flash_cmd.addr})] = flash_cmd.word;
    if (flash_cmd.erase) mem[int'({flash_cmd.data_flash, flash_cmd.addr})] = '1;
    step(0, flash_cmd.rd, int'({flash_cmd.data_flash, flash_cmd.addr}), ok, w);
    if (ok) begin
      flash_ret.valid <= 1'b1;
      flash_ret.word <= w;
    end
    for (int c = 0; c < 2; c++) begin
      sram_ret[c].valid <= 1'b0;
      sram_ret[c].word <= ~sram_ret[c].word;
      if (sram_cmd[c].wr) mem[((c + 1) << 17) + int'(sram_cmd[c].addr)] = 72'(sram_cmd[c].word);
      step(c + 1, sram_cmd[c].rd, ((c + 1) << 17) + int'(sram_cmd[c].addr ^ addr_skew), ok, w);
      if (ok) begin
        sram_ret[c].valid <= 1'b1;
        sram_ret[c].word <= w[38:0];
      end
    end
  end
endmodule

// file: memory_secded_checker.sv
// SEC-DED protection for flash and dual-channel SRAM with fault reporting
//
// Behaviour
// - Any single flipped data bit is corrected on read.
// - Double-bit and detectable wider faults are reported uncorrectable.
// - Code flash codeword is 64 data bits plus 8 check bits; data flash is 32 plus 7.
// - SRAM check bits cover 32 data bits and 16 address lines, 7 bits.
// - SRAM single fault in the address part is not corrected, reported uncorrectable.
// - Check bits are produced on every write and stored with the data.
// - Corrected errors are recorded, one per cycle (flash over SRAM0 over SRAM1); optional interrupt exposes last corrected address.
// - Uncorrectable fault raises the error output, then requests device reset.
// - An all-zero flash word (72 or 39 bits) is uncorrectable.
// - An all-ones flash word (72 or 39 bits) passes with no error.
// - Data flash double error then data flash program causes functional reset.
// - Lockstep sends each channel 0 SRAM access to both controllers, checked independently.
// - Decoupled mode routes each channel to its own controller, checked independently.
`timescale 1ns/1ps
`include "ecc_map.svh"
module memory_secded_checker (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic lockstep_mode,
  input wire logic irq_enable,
  input ecc_pkg::flash_req_t flash_req,
  output ecc_pkg::flash_cmd_t flash_cmd,
  input ecc_pkg::flash_ret_t flash_ret,
  output ecc_pkg::rsp_t flash_rsp,
  input ecc_pkg::sram_req_t [`SR_CHANNELS-1:0] sram_req,
  output ecc_pkg::sram_cmd_t [`SR_CHANNELS-1:0] sram_cmd,
  input ecc_pkg::sram_ret_t [`SR_CHANNELS-1:0] sram_ret,
  output ecc_pkg::rsp_t [`SR_CHANNELS-1:0] sram_rsp,
  output logic [`SR_ADDR_W-1:0] last_corr_addr,
  output ecc_pkg::err_src_t last_corr_src,
  output logic sbe_irq,
  output logic error_out,
  output logic reset_req
);
  localparam int PAD_DF = `FL_WORD_W - `DF_WORD_W;
  localparam int PAD_RSP = `RSP_DATA_W - `DF_DATA_W;

  // ----------------------------------------
  // Mode strap synchroniser
  // ----------------------------------------
  logic ls_meta_reg;
  logic lockstep_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ls_meta_reg <= 1'b0;
      lockstep_reg <= 1'b0;
    end else begin
      ls_meta_reg <= lockstep_mode;
      lockstep_reg <= ls_meta_reg;
    end
  end

  // ----------------------------------------
  // Flash codecs
  // ----------------------------------------
  logic [`FL_CHK_W-1:0] fl_enc_chk;
  logic [`DF_CHK_W-1:0] df_enc_chk;
  logic [`FL_DATA_W-1:0] fl_fixed;
  logic [`DF_DATA_W-1:0] df_fixed;
  logic fl_code_sbe;
  logic fl_code_ue;
  logic df_sbe;
  logic df_ue;

  secded_codec #(
    .DATA_W(`FL_DATA_W),
    .ADDR_W(1),
    .CHK_W(`FL_CHK_W)
  ) u_code_flash_codec (
    .enc_data(flash_req.wdata),
    .enc_addr(1'b0),
    .enc_chk(fl_enc_chk),
    .dec_data(flash_ret.word[`FL_DATA_W-1:0]),
    .dec_addr(1'b0),
    .dec_chk(flash_ret.word[`FL_WORD_W-1:`FL_DATA_W]),
    .dec_fixed(fl_fixed),
    .dec_sbe(fl_code_sbe),
    .dec_ue(fl_code_ue)
  );

  secded_codec #(
    .DATA_W(`DF_DATA_W),
    .ADDR_W(1),
    .CHK_W(`DF_CHK_W)
  ) u_data_flash_codec (
    .enc_data(flash_req.wdata[`DF_DATA_W-1:0]),
    .enc_addr(1'b0),
    .enc_chk(df_enc_chk),
    .dec_data(flash_ret.word[`DF_DATA_W-1:0]),
    .dec_addr(1'b0),
    .dec_chk(flash_ret.word[`DF_WORD_W-1:`DF_DATA_W]),
    .dec_fixed(df_fixed),
    .dec_sbe(df_sbe),
    .dec_ue(df_ue)
  );

  // ----------------------------------------
  // Flash command path
  // ----------------------------------------
  logic fl_pend_df_reg;
  logic [`FL_ADDR_W-1:0] fl_pend_addr_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.rd <= flash_req.valid && !flash_req.write && !flash_req.erase;
      flash_cmd.wr <= flash_req.valid && flash_req.write;
      flash_cmd.erase <= flash_req.valid && flash_req.erase && !flash_req.write;
      flash_cmd.data_flash <= flash_req.data_flash;
      flash_cmd.addr <= flash_req.addr;
      if (flash_req.data_flash) begin
        flash_cmd.word <= {{PAD_DF{1'b0}}, df_enc_chk, flash_req.wdata[`DF_DATA_W-1:0]};
      end else begin
        flash_cmd.word <= {fl_enc_chk, flash_req.wdata};
      end
    end
  end

  // One read outstanding: the array answers in request order
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fl_pend_df_reg <= 1'b0;
      fl_pend_addr_reg <= '0;
    end else if (flash_req.valid && !flash_req.write && !flash_req.erase) begin
      fl_pend_df_reg <= flash_req.data_flash;
      fl_pend_addr_reg <= flash_req.addr;
    end
  end

  // ----------------------------------------
  // Flash read check
  // ----------------------------------------
  logic fl_all0;
  logic fl_all1;
  logic fl_sbe;
  logic fl_ue;
  logic [`RSP_DATA_W-1:0] fl_data;
  logic fl_sbe_now;
  logic fl_ue_now;

  always_comb begin
    fl_all0 = fl_pend_df_reg ? (flash_ret.word[`DF_WORD_W-1:0] == '0) : (flash_ret.word == '0);
    fl_all1 = fl_pend_df_reg ? (&flash_ret.word[`DF_WORD_W-1:0]) : (&flash_ret.word);
    fl_sbe = fl_pend_df_reg ? df_sbe : fl_code_sbe;
    fl_ue = fl_pend_df_reg ? df_ue : fl_code_ue;
    fl_data = fl_pend_df_reg ? {{PAD_RSP{1'b0}}, df_fixed} : fl_fixed;
    if (fl_all1) begin
      // Erased word: pass raw, whatever the syndrome says
      fl_sbe = 1'b0;
      fl_ue = 1'b0;
      fl_data = fl_pend_df_reg ? {{PAD_RSP{1'b0}}, flash_ret.word[`DF_DATA_W-1:0]}
                               : flash_ret.word[`FL_DATA_W-1:0];
    end else if (fl_all0) begin
      fl_sbe = 1'b0;
      fl_ue = 1'b1;
    end
  end

  assign fl_sbe_now = flash_ret.valid && fl_sbe;
  assign fl_ue_now = flash_ret.valid && fl_ue;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flash_rsp <= '0;
    end else begin
      flash_rsp.valid <= flash_ret.valid;
      flash_rsp.single_bit_error <= fl_sbe_now;
      flash_rsp.ue <= fl_ue_now;
      flash_rsp.rdata <= fl_data;
    end
  end

  // ----------------------------------------
  // Data flash program hazard
  // ----------------------------------------
  logic ded_pend_reg;
  logic prog_reset_reg;
  logic df_clean_read;
  logic df_erase;
  logic df_program;

  assign df_clean_read = flash_ret.valid && fl_pend_df_reg && !fl_ue;
  assign df_erase = flash_req.valid && flash_req.data_flash && flash_req.erase;
  assign df_program = flash_req.valid && flash_req.data_flash && flash_req.write;

  // A new double error wins over a clean read or erase in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ded_pend_reg <= 1'b0;
    end else if (fl_ue_now && fl_pend_df_reg) begin
      ded_pend_reg <= 1'b1;
    end else if (df_clean_read || df_erase) begin
      ded_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prog_reset_reg <= 1'b0;
    end else begin
      prog_reset_reg <= ded_pend_reg && df_program;
    end
  end

  // ----------------------------------------
  // SRAM controllers
  // ----------------------------------------
  logic sr_sbe_now [`SR_CHANNELS];
  logic sr_ue_now [`SR_CHANNELS];
  logic [`SR_ADDR_W-1:0] sr_addr [`SR_CHANNELS];

  for (genvar ch = 0; ch < `SR_CHANNELS; ch++) begin : g_ctrl
    ecc_pkg::sram_req_t sel;
    ecc_pkg::sram_cmd_t cmd_reg;
    ecc_pkg::rsp_t rsp_reg;
    logic [`SR_ADDR_W-1:0] pend_addr_reg;
    logic [`SR_CHK_W-1:0] enc_chk;
    logic [`SR_DATA_W-1:0] fixed;
    logic single_bit_error;
    logic ue;

    // Lockstep: every controller serves channel 0
    assign sel = (lockstep_reg && ch != 0) ? sram_req[0] : sram_req[ch];

    secded_codec #(
      .DATA_W(`SR_DATA_W),
      .ADDR_W(`SR_ADDR_W),
      .CHK_W(`SR_CHK_W)
    ) u_sram_codec (
      .enc_data(sel.wdata),
      .enc_addr(sel.addr),
      .enc_chk(enc_chk),
      .dec_data(sram_ret[ch].word[`SR_DATA_W-1:0]),
      .dec_addr(pend_addr_reg),
      .dec_chk(sram_ret[ch].word[`SR_WORD_W-1:`SR_DATA_W]),
      .dec_fixed(fixed),
      .dec_sbe(single_bit_error),
      .dec_ue(ue)
    );

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        cmd_reg <= '0;
      end else begin
        cmd_reg.rd <= sel.valid && !sel.write;
        cmd_reg.wr <= sel.valid && sel.write;
        cmd_reg.addr <= sel.addr;
        cmd_reg.word <= {enc_chk, sel.wdata};
      end
    end

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        pend_addr_reg <= '0;
      end else if (sel.valid && !sel.write) begin
        pend_addr_reg <= sel.addr;
      end
    end

    assign sr_sbe_now[ch] = sram_ret[ch].valid && single_bit_error;
    assign sr_ue_now[ch] = sram_ret[ch].valid && ue;
    assign sr_addr[ch] = pend_addr_reg;

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        rsp_reg <= '0;
      end else begin
        rsp_reg.valid <= sram_ret[ch].valid;
        rsp_reg.single_bit_error <= sr_sbe_now[ch];
        rsp_reg.ue <= sr_ue_now[ch];
        rsp_reg.rdata <= {{PAD_RSP{1'b0}}, fixed};
      end
    end

    assign sram_cmd[ch] = cmd_reg;
    assign sram_rsp[ch] = rsp_reg;
  end

  // ----------------------------------------
  // Error collection
  // ----------------------------------------
  logic ls_mismatch;
  logic ue_any;
  logic sbe_any;
  logic [`SR_ADDR_W-1:0] sbe_addr;
  ecc_pkg::err_src_t sbe_src;

  // Disagreeing lockstep channels mean one checker is faulty
  assign ls_mismatch = lockstep_reg && sram_rsp[0].valid && (sram_rsp[0] != sram_rsp[1]);
  assign ue_any = fl_ue_now || sr_ue_now[0] || sr_ue_now[1] || ls_mismatch;
  assign sbe_any = fl_sbe_now || sr_sbe_now[0] || sr_sbe_now[1];

  always_comb begin
    sbe_addr = fl_pend_addr_reg;
    sbe_src = ecc_pkg::SRC_FLASH;
    if (!fl_sbe_now && sr_sbe_now[0]) begin
      sbe_addr = sr_addr[0];
      sbe_src = ecc_pkg::SRC_SRAM0;
    end else if (!fl_sbe_now && sr_sbe_now[1]) begin
      sbe_addr = sr_addr[1];
      sbe_src = ecc_pkg::SRC_SRAM1;
    end
  end

  error_reporter #(
    .ADDR_W(`SR_ADDR_W),
    .LEAD(`ERR_LEAD_CYCLES)
  ) u_reporter (
    .ref_clk(ref_clk),
    .srst(srst),
    .sbe_event(sbe_any),
    .sbe_addr(sbe_addr),
    .sbe_src(sbe_src),
    .ue_event(ue_any),
    .prog_reset(prog_reset_reg),
    .irq_enable(irq_enable),
    .last_corr_addr(last_corr_addr),
    .last_corr_src(last_corr_src),
    .sbe_irq(sbe_irq),
    .error_out(error_out),
    .reset_req(reset_req)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_sram_write_enc: assert property (
    sram_req[0].valid && sram_req[0].write
      |=> sram_cmd[0].wr && sram_cmd[0].word[`SR_DATA_W-1:0] == $past(sram_req[0].wdata)
  ) else $error("SRAM write not issued with its data");

  a_lockstep_both: assert property (
    lockstep_reg && sram_req[0].valid |=> sram_cmd[0] == sram_cmd[1]
  ) else $error("lockstep access did not reach both controllers");

  a_decoupled_own: assert property (
    !lockstep_reg && sram_req[1].valid
      |=> sram_cmd[1].addr == $past(sram_req[1].addr) && (sram_cmd[1].rd || sram_cmd[1].wr)
  ) else $error("decoupled channel not routed to its controller");

  a_zero_word_ue: assert property (
    flash_ret.valid && flash_ret.word == '0 |=> flash_rsp.ue && !flash_rsp.single_bit_error
  ) else $error("all-zero flash word not flagged");

  a_ones_word_ok: assert property (
    flash_ret.valid && (&flash_ret.word) |=> flash_rsp.valid && !flash_rsp.ue && !flash_rsp.single_bit_error
  ) else $error("all-ones flash word flagged");

  a_ue_error_out: assert property (
    flash_rsp.ue || sram_rsp[0].ue || sram_rsp[1].ue |-> error_out || reset_req
  ) else $error("uncorrectable fault without error output");

  a_df_prog_reset: assert property (
    ded_pend_reg && df_program |-> ##2 reset_req
  ) else $error("program after data flash double error did not reset");

endmodule

// file: memory_secded_checker_tb.sv
// Self-checking bench for the memory SEC-DED checker
`timescale 1ns/1ps
module memory_secded_checker_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic lockstep_mode = 1'b0;
  logic irq_enable = 1'b1;
  ecc_pkg::flash_req_t flash_req = '0;
  ecc_pkg::flash_cmd_t flash_cmd;
  ecc_pkg::flash_ret_t flash_ret;
  ecc_pkg::rsp_t flash_rsp;
  ecc_pkg::sram_req_t [1:0] sram_req = '0;
  ecc_pkg::sram_cmd_t [1:0] sram_cmd;
  ecc_pkg::sram_ret_t [1:0] sram_ret;
  ecc_pkg::rsp_t [1:0] sram_rsp;
  logic [15:0] last_corr_addr;
  ecc_pkg::err_src_t last_corr_src;
  logic sbe_irq;
  logic error_out;
  logic reset_req;
  logic [71:0] flip = '0;
  logic [15:0] addr_skew = '0;
  logic force_on = 1'b0;
  logic [71:0] force_word = '0;
  logic [3:0] lag = 4'h0;
  int fail_count = 0;
  int total_checks = 0;
  ecc_pkg::rsp_t rsp;
  ecc_pkg::rsp_t rsp1;
  logic irq_seen;
  logic err_seen;

  always #2.5 ref_clk = ~ref_clk;

  memory_secded_checker u_memory_secded_checker (.ref_clk, .srst, .lockstep_mode,
    .irq_enable, .flash_req, .flash_cmd, .flash_ret, .flash_rsp, .sram_req, .sram_cmd,
    .sram_ret, .sram_rsp, .last_corr_addr, .last_corr_src, .sbe_irq, .error_out, .reset_req);
  mem_array_model u_mem_array_model (.ref_clk, .flash_cmd, .flash_ret, .sram_cmd, .sram_ret,
    .flip, .addr_skew, .force_on, .force_word, .lag);

  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Extra edges let the mode synchroniser settle
  task automatic do_reset();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_rsp(input int ch);
    for (int n = 0; n < 30; n++) begin
      @(posedge ref_clk);
      #1;
      rsp = ch == 2 ? flash_rsp : sram_rsp[ch];
      if (rsp.valid === 1'b1) begin
        rsp1 = sram_rsp[1];
        irq_seen = sbe_irq;
        err_seen = error_out;
        return;
      end
    end
    fail_count++;
    tally_and_finish();
  endtask

  task automatic flash_op(input logic wr, er, df, input logic [15:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    flash_req <= {1'b1, wr, er, df, a, d};
    @(posedge ref_clk);
    flash_req.valid <= 1'b0;
    #1;
    check({flash_cmd.rd, flash_cmd.wr, flash_cmd.erase}, {!wr && !er, wr, er && !wr});
    if (wr) check(df ? flash_cmd.word[31:0] : flash_cmd.word[63:0], df ? d[31:0] : d);
  endtask

  task automatic flash_rd(input logic df, input logic [15:0] a);
    flash_op(1'b0, 1'b0, df, a, '0);
    wait_rsp(2);
  endtask

  task automatic sram_op(input int ch, input logic wr, input logic [15:0] a,
                         input logic [31:0] d);
    @(posedge ref_clk);
    sram_req[ch] <= {1'b1, wr, a, d};
    @(posedge ref_clk);
    sram_req[ch].valid <= 1'b0;
    #1;
    check(sram_cmd[ch].wr, wr);
    if (!wr) wait_rsp(ch);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic sc_flash_single();
    int pos [5] = '{0, 37, 63, 64, 71};
    flash_op(1'b1, 1'b0, 1'b0, 16'h0010, 64'h0123_4567_89AB_CDEF);
    flash_rd(1'b0, 16'h0010);
    check({rsp.single_bit_error, rsp.ue, rsp.rdata}, {2'h0, 64'h0123_4567_89AB_CDEF});
    foreach (pos[i]) begin
      @(posedge ref_clk);
      irq_enable <= (i != 4);
      flip = 72'h1 << pos[i];
      flash_rd(1'b0, 16'h0010);
      check({rsp.single_bit_error, rsp.ue, irq_seen}, {2'h2, i != 4});
      check(rsp.rdata, 64'h0123_4567_89AB_CDEF);
      check({last_corr_src, last_corr_addr}, {ecc_pkg::SRC_FLASH, 16'h0010});
    end
    flip = '0;
  endtask

  task automatic sc_flash_double();
    lag = 4'h5;
    flash_op(1'b1, 1'b0, 1'b0, 16'h0020, 64'hFEDC_BA98_7654_3210);
    flip = 72'h10_0008;
    flash_rd(1'b0, 16'h0020);
    flip = '0;
    lag = 4'h0;
    check({rsp.single_bit_error, rsp.ue, err_seen}, 3'h3);
    repeat (15) @(posedge ref_clk);
    #1;
    check(reset_req, 1'b0);
    @(posedge ref_clk);
    #1;
    check(reset_req, 1'b1);
    do_reset();
  endtask

  task automatic sc_blank();
    for (int df = 0; df < 2; df++) begin
      force_on = 1'b1;
      force_word = df ? 72'h7F_FFFF_FFFF : '1;
      flash_rd(df[0], 16'h0030);
      check({rsp.single_bit_error, rsp.ue}, 2'h0);
      check(rsp.rdata, df ? 64'hFFFF_FFFF : 64'hFFFF_FFFF_FFFF_FFFF);
      force_word = '0;
      flash_rd(df[0], 16'h0030);
      check({rsp.single_bit_error, rsp.ue}, 2'h1);
      force_on = 1'b0;
      do_reset();
    end
  endtask

  task automatic sc_sram();
    sram_op(0, 1'b1, 16'h0042, 32'hCAFE_F00D);
    flip = 72'h20;
    sram_op(0, 1'b0, 16'h0042, '0);
    check({rsp.single_bit_error, rsp.ue, rsp.rdata}, {2'h2, 64'hCAFE_F00D});
    check(last_corr_src, ecc_pkg::SRC_SRAM0);
    flip = 72'h2_0000_0000;
    sram_op(0, 1'b0, 16'h0042, '0);
    check({rsp.single_bit_error, rsp.ue, rsp.rdata}, {2'h2, 64'hCAFE_F00D});
    sram_op(1, 1'b1, 16'h0042, 32'h1357_9BDF);
    check(sram_cmd[0].wr, 1'b0);
    flip = 72'h4000_0000;
    sram_op(1, 1'b0, 16'h0042, '0);
    check({rsp.single_bit_error, rsp.ue, rsp.rdata}, {2'h2, 64'h1357_9BDF});
    check(last_corr_src, ecc_pkg::SRC_SRAM1);
    flip = '0;
    sram_op(0, 1'b0, 16'h0042, '0);
    check({rsp.single_bit_error, rsp.ue, rsp.rdata}, {2'h0, 64'hCAFE_F00D});
    addr_skew = 16'h0100;
    sram_op(0, 1'b0, 16'h0142, '0);
    check({rsp.single_bit_error, rsp.ue, err_seen}, 3'h3);
    addr_skew = '0;
    do_reset();
  endtask

  task automatic sc_lockstep();
    @(posedge ref_clk);
    lockstep_mode <= 1'b1;
    do_reset();
    sram_op(0, 1'b1, 16'h0077, 32'h2468_ACE0);
    check(sram_cmd[1], sram_cmd[0]);
    flip = 72'h1000;
    sram_op(0, 1'b0, 16'h0077, '0);
    flip = '0;
    check({rsp.single_bit_error, rsp.ue, rsp.rdata}, {2'h2, 64'h2468_ACE0});
    check(rsp1, rsp);
    @(posedge ref_clk);
    lockstep_mode <= 1'b0;
    do_reset();
  endtask

  // Hazard cleared by an erase or a clean read in between
  task automatic sc_prog_hazard(input int v);
    flash_op(1'b1, 1'b0, 1'b1, 16'h0050, 64'h0BAD_F00D);
    flip = 72'h10_0008;
    flash_rd(1'b1, 16'h0050);
    flip = '0;
    check(rsp.ue, 1'b1);
    if (v == 1) flash_op(1'b0, 1'b1, 1'b1, 16'h0050, '0);
    if (v == 2) flash_rd(1'b1, 16'h0050);
    flash_op(1'b1, 1'b0, 1'b1, 16'h0050, 64'h0BAD_F00D);
    repeat (2) @(posedge ref_clk);
    #1;
    check(reset_req, v == 0);
    do_reset();
  endtask

  initial begin
    do_reset();
    sc_flash_single();
    sc_flash_double();
    sc_blank();
    sc_sram();
    sc_lockstep();
    for (int v = 0; v < 3; v++) sc_prog_hazard(v);
    tally_and_finish();
  end
endmodule

// file: secded_codec.sv
// Hsiao SEC-DED encoder and checker with optional address folding
`timescale 1ns/1ps
module secded_codec #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 16,
  parameter int CHK_W = 7
) (
  input wire logic [DATA_W-1:0] enc_data,
  input wire logic [ADDR_W-1:0] enc_addr,
  output logic [CHK_W-1:0] enc_chk,
  input wire logic [DATA_W-1:0] dec_data,
  input wire logic [ADDR_W-1:0] dec_addr,
  input wire logic [CHK_W-1:0] dec_chk,
  output logic [DATA_W-1:0] dec_fixed,
  output logic dec_sbe,
  output logic dec_ue
);
  localparam int N = DATA_W + ADDR_W;

  if (CHK_W < 4 || CHK_W > 8 || ADDR_W < 1 || N > (1 << (CHK_W - 1)) - CHK_W) begin : g_bad
    $error("secded_codec: too few check bits for the word");
  end

  // Distinct odd-weight columns of weight three or more
  function automatic logic [CHK_W-1:0] column(input int idx);
    int seen;
    logic [CHK_W-1:0] v;
    seen = 0;
    column = '0;
    for (int c = 1; c < (1 << CHK_W); c++) begin
      v = CHK_W'(c);
      if ($countones(v) >= 3 && $countones(v) % 2 == 1) begin
        if (seen == idx) column = v;
        seen++;
      end
    end
  endfunction

  logic [N-1:0] enc_in;
  logic [N-1:0] dec_in;
  logic [N-1:0] hit;
  logic [CHK_W-1:0] dec_par;
  logic [CHK_W-1:0] syn;
  logic chk_only;

  assign enc_in = {enc_addr, enc_data};
  assign dec_in = {dec_addr, dec_data};

  always_comb begin
    enc_chk = '0;
    for (int i = 0; i < N; i++) begin
      if (enc_in[i]) begin
        enc_chk ^= column(i);
      end
    end
  end

  always_comb begin
    dec_par = '0;
    for (int i = 0; i < N; i++) begin
      if (dec_in[i]) begin
        dec_par ^= column(i);
      end
    end
  end

  assign syn = dec_par ^ dec_chk;

  for (genvar i = 0; i < N; i++) begin : g_hit
    assign hit[i] = (syn == column(i));
  end

  assign chk_only = ($countones(syn) == 1);
  assign dec_fixed = dec_data ^ hit[DATA_W-1:0];
  assign dec_sbe = (|hit[DATA_W-1:0]) | chk_only;
  // Address-column hits fall through here: never corrected
  assign dec_ue = (syn != '0) & ~dec_sbe;

endmodule
